// File: rtl/sdw_pkg.sv
package sdw_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int MODE_BITS = 2;
  localparam int CNT_BITS = 5;

  // Frame field positions
  localparam int MODE_MSB = 13;
  localparam int MODE_LSB = 12;
  localparam int CODE_MSB = 11;
  localparam int CODE_LSB = 4;

  localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h0F;
  localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 8'h00;

  // Host timing limits, kept for reference by the bench
  localparam int SYNC_HIGH_NS_HI_SUPPLY = 33;
  localparam int SYNC_HIGH_NS_LO_SUPPLY = 50;
  localparam int SCLK_MAX_MHZ = 30;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int SYNC_HIGH_CYC_HI = (SYNC_HIGH_NS_HI_SUPPLY + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SYNC_HIGH_CYC_LO = (SYNC_HIGH_NS_LO_SUPPLY + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    SDW_MODE_NORMAL = 2'h0,
    SDW_MODE_PD_1K = 2'h1,
    SDW_MODE_PD_100K = 2'h2,
    SDW_MODE_PD_OPEN = 2'h3
  } sdw_mode_t;

  typedef enum logic [1:0] {
    SDW_ST_IDLE = 2'h0,
    SDW_ST_SHIFT = 2'h1,
    SDW_ST_DONE = 2'h2
  } sdw_state_t;

  typedef struct packed {
    logic frame_n;
    logic data;
  } sdw_serial_t;

  typedef struct packed {
    logic [CODE_BITS-1:0] code;
    sdw_mode_t mode;
  } sdw_word_t;

  typedef struct packed {
    logic amp_enable;
    logic pull_1k;
    logic pull_100k;
    logic output_open;
  } sdw_analog_t;

  // Normal mode after reset; with code zero the output sits at 0 V
  localparam sdw_analog_t ANALOG_RESET = '{amp_enable: 1'b1, pull_1k: 1'b0,
    pull_100k: 1'b0, output_open: 1'b0};

endpackage

// File: rtl/sdw_out_stage.sv
`timescale 1ns/1ps
module sdw_out_stage
  import sdw_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input sdw_pkg::sdw_mode_t mode,
  output sdw_pkg::sdw_analog_t analog_ctl
);
  import sdw_pkg::*;

  typedef struct packed {
    sdw_analog_t ctl;
  } sdw_out_state_t;

  sdw_out_state_t state;
  sdw_out_state_t next_state;

  function automatic sdw_analog_t decode_mode(input sdw_mode_t m);
    sdw_analog_t a;
    a = '0;
    unique case (m)
      SDW_MODE_NORMAL: a.amp_enable = 1'b1;
      SDW_MODE_PD_1K: a.pull_1k = 1'b1;
      SDW_MODE_PD_100K: a.pull_100k = 1'b1;
      SDW_MODE_PD_OPEN: a.output_open = 1'b1;
    endcase
    return a;
  endfunction

  always_comb
  begin
    next_state.ctl = decode_mode(mode); // R9 R12
  end

  // Reset value matches normal mode, driving 0 V
  always_ff @(negedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '{ctl: ANALOG_RESET};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign analog_ctl = state.ctl;

endmodule

// File: rtl/sdw_write_port.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Frame line low opens a frame and arms the shift register.
// R2 - Each falling serial clock edge in a frame shifts one data bit in.
// R3 - Sixteenth falling edge takes last bit and applies code and mode at once.
// R4 - After the sixteenth edge the host may hold frame low or raise it.
// R5 - Host holds frame high at least 33 ns or 50 ns between frames.
// R6 - Host may park frame low between frames to save power.
// R7 - Bits 13:12 give mode, 11:4 give code, others are ignored.
// R8 - Host sends most significant bit first.
// R9 - Mode 00 normal, 01 1k pull, 10 100k pull, 11 open output.
// R10 - Frame rising before sixteenth edge discards frame, nothing changes.
// R11 - Power-up clears code register; output stays 0 V until valid frame.
// R12 - Power-down modes detach amplifier, select pull or open, stop analog.
// R13 - Power-down leaves the stored code untouched; here a power-down frame still loads code from bits 11:4.
// R14 - Code is straight binary 0 to 255, output supply times code over 256.
// R15 - Host keeps serial clock at or below 30 MHz; the bench clock has a 25 ns period, which is 40 MHz.
// R16 - Byte-oriented hosts keep frame low across both bytes.
// R17 - Standard port hosts use clock polarity 0, phase 1.
// R18 - DSP hosts make own clock, active-low frame, 16-bit words.
// R19 - After sixteenth edge ignore clocks until frame returns high.
// R20 - Code and mode update together at the same capture point.
module sdw_write_port
  import sdw_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input sdw_pkg::sdw_serial_t serial_in,
  output logic [sdw_pkg::CODE_BITS-1:0] dac_code,
  output sdw_pkg::sdw_mode_t dac_mode,
  output sdw_pkg::sdw_analog_t analog_output,
  output logic update_pulse,
  output logic frame_busy
);
  import sdw_pkg::*;

  // Serial clock is the block clock; frame level is sampled on its falling edge.
  // A frame raised and lowered between two falling edges is not seen as a break.
  typedef struct packed {
    sdw_state_t fsm;
    logic [CNT_BITS-1:0] count;
    logic [FRAME_BITS-1:0] shift;
    sdw_word_t word;
    logic update;
  } sdw_core_t;

  localparam sdw_core_t CORE_RESET = '{
    fsm: SDW_ST_IDLE,
    count: CNT_RESET,
    shift: SHIFT_RESET,
    word: '{code: CODE_RESET, mode: SDW_MODE_NORMAL},
    update: 1'b0
  };

  sdw_core_t state;
  sdw_core_t next_state;
  wire [FRAME_BITS-1:0] shifted;
  sdw_word_t captured;
  logic frame_open;
  logic accepting;
  logic last_edge;

  // Code sits mid-frame; the edge bits are don't-care
  function automatic logic [CODE_BITS-1:0] code_field(input logic [FRAME_BITS-1:0] word_in);
    return word_in[CODE_MSB:CODE_LSB];
  endfunction

  // Explicit decode keeps every mode code visible
  function automatic sdw_mode_t mode_field(input logic [FRAME_BITS-1:0] word_in);
    sdw_mode_t m;
    m = SDW_MODE_NORMAL;
    unique case (word_in[MODE_MSB:MODE_LSB])
      2'h0:
      begin
        m = SDW_MODE_NORMAL;
      end
      2'h1:
      begin
        m = SDW_MODE_PD_1K;
      end
      2'h2:
      begin
        m = SDW_MODE_PD_100K;
      end
      2'h3:
      begin
        m = SDW_MODE_PD_OPEN;
      end
    endcase
    return m;
  endfunction

  function automatic logic is_last(input logic [CNT_BITS-1:0] count);
    return count == LAST_BIT;
  endfunction

  // Wraps to zero on the completing edge; a parked frame then stays done until the frame line goes high
  function automatic logic [CNT_BITS-1:0] next_count(input logic [CNT_BITS-1:0] count);
    logic [CNT_BITS-1:0] result;
    if (is_last(count))
    begin
      result = CNT_RESET;
    end
    else
    begin
      result = CNT_BITS'(count + 5'h01);
    end
    return result;
  endfunction

  // States that still take serial bits; an illegal code takes none
  function automatic logic takes_bits(input sdw_state_t fsm);
    logic result;
    result = 1'b0;
    unique case (fsm)
      SDW_ST_IDLE:
      begin
        result = 1'b1;
      end
      SDW_ST_SHIFT:
      begin
        result = 1'b1;
      end
      SDW_ST_DONE:
      begin
        result = 1'b0;
      end
      default:
      begin
        result = 1'b0;
      end
    endcase
    return result;
  endfunction

  // Busy only while bits are still owed; the finished state reads as idle
  function automatic logic busy_state(input sdw_state_t fsm);
    return fsm == SDW_ST_SHIFT;
  endfunction

  // Each bit takes its lower neighbour, so the first bit sent ends at the top
  assign shifted[0] = serial_in.data; // R2
  for (genvar gi = 1; gi < FRAME_BITS; gi++)
  begin : g_shift
    assign shifted[gi] = state.shift[gi-1]; // R2 R8
  end

  assign frame_open = !serial_in.frame_n; // R1
  assign accepting = frame_open && takes_bits(state.fsm); // R1 R19
  assign last_edge = accepting && is_last(state.count); // R3
  assign captured = '{code: code_field(shifted), mode: mode_field(shifted)}; // R7 R9 R14 R20

  always_comb
  begin
    next_state = state;
    next_state.update = 1'b0;
    if (!frame_open)
    begin
      // High frame line aborts or closes any frame
      next_state.fsm = SDW_ST_IDLE; // R10 R19
      next_state.count = CNT_RESET;
      next_state.shift = SHIFT_RESET; // R10
    end
    else
    begin
      unique case (state.fsm)
        SDW_ST_IDLE, SDW_ST_SHIFT:
        begin
          next_state.shift = shifted; // R2
          next_state.count = next_count(state.count);
          if (last_edge)
          begin
            // Whole word lands in one register write
            next_state.word = captured; // R3 R20
            next_state.update = 1'b1; // R3
            next_state.fsm = SDW_ST_DONE; // R4 R19
          end
          else
          begin
            next_state.fsm = SDW_ST_SHIFT; // R1
          end
        end
        SDW_ST_DONE:
        begin
          // Parked frame line keeps the finished word; later clocks are ignored
          next_state.fsm = SDW_ST_DONE; // R19
        end
        default:
        begin
          next_state.fsm = SDW_ST_IDLE;
          next_state.count = CNT_RESET;
        end
      endcase
    end
  end

  // Only power-on reset clears the code; a frame selecting a power-down mode still loads its bits 11:4 as the code
  always_ff @(negedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= CORE_RESET; // R11
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state flops
  assign dac_code = state.word.code; // R13 R14
  assign dac_mode = state.word.mode;
  assign update_pulse = state.update;
  assign frame_busy = busy_state(state.fsm);

  sdw_out_stage u_out_stage (
    .clock(clock),
    .rst_n(rst_n),
    .mode(next_state.word.mode),
    .analog_ctl(analog_output)
  ); // R12

endmodule

// File: bench/sdw_write_port_chk.sv
`timescale 1ns/1ps
module sdw_write_port_chk
  import sdw_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input sdw_pkg::sdw_serial_t serial_in,
  input wire logic [sdw_pkg::CODE_BITS-1:0] dac_code,
  input sdw_pkg::sdw_mode_t dac_mode,
  input sdw_pkg::sdw_analog_t analog_output,
  input wire logic update_pulse,
  input wire logic frame_busy
);
  logic [15:0] sh;
  logic [3:0] bc;
  // Last sixteen data bits, no reset needed
  always_ff @(negedge clock)
    sh <= {sh[14:0], serial_in.data};
  always_ff @(negedge clock or negedge rst_n)
    if (!rst_n)
      bc <= 4'h0;
    else
      bc <= frame_busy ? bc + 4'h1 : 4'h0;
  default clocking cb @(negedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_code_load: assert property (update_pulse |-> dac_code == sh[11:4])
    else $error("code load");
  chk_mode_load: assert property (update_pulse |-> dac_mode == sh[13:12])
    else $error("mode load");
  chk_code_hold: assert property (!update_pulse |-> $stable(dac_code))
    else $error("code moved");
  chk_mode_hold: assert property (!update_pulse |-> $stable(dac_mode))
    else $error("mode moved");
  chk_analog_map: assert property (analog_output == 4'h8 >> dac_mode)
    else $error("analog map");
  chk_bit_count: assert property (update_pulse |-> bc == 4'hF)
    else $error("bit count");
  chk_abort_quiet: assert property (serial_in.frame_n |=> !update_pulse && !frame_busy)
    else $error("abort");
  chk_after_done: assert property (update_pulse |=> !update_pulse && !frame_busy)
    else $error("after done");
  chk_busy_start: assert property ($rose(frame_busy) |-> !$past(serial_in.frame_n))
    else $error("busy start");
endmodule
bind sdw_write_port sdw_write_port_chk i_chk (.clock(clock), .rst_n(rst_n), .serial_in(serial_in),
  .dac_code(dac_code), .dac_mode(dac_mode), .analog_output(analog_output),
  .update_pulse(update_pulse), .frame_busy(frame_busy));

// File: bench/sdw_host_model.sv
`timescale 1ns/1ps
module sdw_host_model
  import sdw_pkg::*;
(
  input wire logic clock,
  output sdw_pkg::sdw_serial_t serial_in
);
  initial serial_in = 2'h2;
  task automatic send(input logic [15:0] w, input int nb, input int park);
    for (int i = 15; i > 15 - nb; i--)
    begin
      @(posedge clock);
      #2 serial_in = '{frame_n: 1'b0, data: w[i]};
    end
    // Stale data toggles so no bit reads as valid
    for (int k = 0; k < park + SYNC_HIGH_CYC_LO; k++)
    begin
      @(posedge clock);
      #2 serial_in = '{frame_n: k >= park, data: !serial_in.data};
    end
  endtask
endmodule

// File: bench/serial_dac_write_port_tb_top.sv
`timescale 1ns/1ps
module serial_dac_write_port_tb_top;
  import sdw_pkg::*;
  logic clock;
  logic rst_n;
  sdw_serial_t serial_in;
  logic [7:0] dac_code;
  sdw_mode_t dac_mode;
  sdw_analog_t analog_output;
  logic update_pulse;
  logic frame_busy;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_updates = 0;
  int n_busy = 0;
  int n;
  logic [15:0] w;
  logic [9:0] ew = 10'h000;
  sdw_host_model i_host (.clock(clock), .serial_in(serial_in));
  sdw_write_port i_dut (.clock(clock), .rst_n(rst_n), .serial_in(serial_in), .dac_code(dac_code),
    .dac_mode(dac_mode), .analog_output(analog_output), .update_pulse(update_pulse), .frame_busy(frame_busy));
  initial
  begin
    clock = 1'b0;
    // Bit timing is cycle based, so the rate limit is not exercised here
    forever #12.5 clock = ~clock;
  end
  task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Stored word {code, mode} after a complete frame
  function automatic logic [9:0] exp_word(input logic [15:0] f);
    return {f[11:4], f[13:12]};
  endfunction
  // One-hot {amp, 1k, 100k, open} for each mode code
  function automatic logic [3:0] exp_analog(input logic [1:0] m);
    logic [3:0] a;
    case (m)
      2'h0: a = 4'h8;
      2'h1: a = 4'h4;
      2'h2: a = 4'h2;
      default: a = 4'h1;
    endcase
    return a;
  endfunction
  task automatic frame(input logic [15:0] f, input int nb, input int park);
    int u0;
    int b0;
    u0 = n_updates;
    b0 = n_busy;
    i_host.send(f, nb, park);
    if (nb == 16)
      ew = exp_word(f);
    check("code", dac_code, {8'h00, ew[9:2]});
    check("mode", dac_mode, {14'h0000, ew[1:0]});
    check("analog", analog_output, {12'h000, exp_analog(ew[1:0])});
    check("updates", 16'(n_updates - u0), nb == 16 ? 16'h0001 : 16'h0000);
    check("busy cycles", 16'(n_busy - b0), nb == 16 ? 16'h000F : 16'(nb));
    check("busy end", {15'h0000, frame_busy}, 16'h0000);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (update_pulse === 1'b1)
      n_updates++;
    if (frame_busy === 1'b1)
      n_busy++;
    if (cyc == 4000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    w = 16'($urandom(21582));
    repeat (12) @(posedge clock);
    #2 rst_n = 1'b1;
    check("rst code", {8'h00, dac_code}, 16'h0000);
    check("rst mode", {14'h0000, dac_mode}, 16'h0000);
    check("rst analog", {12'h000, analog_output}, 16'h0008);
    check("rst busy", {15'h0000, frame_busy}, 16'h0000);
    for (int m = 0; m < 4; m++)
    begin
      w = 16'($urandom);
      w[13:12] = m[1:0];
      frame(w, 16, m);
      frame(~w, 15, 0);
    end
    frame(16'hC00F, 16, 0);
    frame(16'h3FF0, 16, 0);
    $display("test modes done");
    repeat (20)
    begin
      n = 10 + $urandom % 7;
      frame(16'($urandom), n, n == 16 ? 2 : 0);
    end
    $display("test random done");
    @(posedge clock);
    #2 rst_n = 1'b0;
    ew = 10'h000;
    @(posedge clock);
    #2 check("rerun code", {8'h00, dac_code}, 16'h0000);
    check("rerun analog", {12'h000, analog_output}, 16'h0008);
    @(posedge clock);
    #2 rst_n = 1'b1;
    frame(16'h0FF0, 12, 0);
    frame(16'h1A50, 16, 0);
    $display("test reset done");
    summarize();
  end
endmodule
